// file: rtl/dsi_pkg.sv
package dsi_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_SLEEP_ENTRY = 8'hb9;
	localparam logic [7:0] OP_WAKE_IDENT  = 8'hab;
	localparam logic [7:0] OP_MFR_DEV_ID  = 8'h90;
	localparam logic [7:0] OP_SOFT_RESET  = 8'h99;

	// ----------------------------------------------------------------
	// identifiers (values arbitrary)
	// ----------------------------------------------------------------
	localparam logic [7:0] MAKER_ID  = 8'h5a;
	localparam logic [7:0] DEVICE_ID = 8'h17;

	// ----------------------------------------------------------------
	// frame layout in rising clock edges
	// ----------------------------------------------------------------
	localparam logic [5:0]  OP_LAST_BIT   = 6'h07;
	localparam logic [5:0]  OP_BITS       = 6'h08;
	localparam logic [5:0]  ADDR_LAST_BIT = 6'h1f;
	localparam logic [5:0]  DATA_START    = 6'h20;
	localparam logic [5:0]  CNT_SAT       = 6'h21;
	localparam logic [23:0] ADDR_SWAP     = 24'h000001;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ              = 25;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS        = 3000;
	localparam int WAKE_IDENT_DELAY_NS  = 3000;
	localparam int TMR_W                = 12;

	localparam logic [TMR_W-1:0] SLEEP_ENTRY_CYC =
		TMR_W'((SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] WAKE_CYC =
		TMR_W'((WAKE_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] WAKE_IDENT_CYC =
		TMR_W'((WAKE_IDENT_DELAY_NS * CLK_MHZ + 999) / 1000);

	// ----------------------------------------------------------------
	// power states
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_AWAKE = 4'b0001,
		ST_ENTER = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_WAKE  = 4'b1000
	} dsi_pwr_state_t;

endpackage

// file: rtl/dsi_sync.sv
// two-stage level synchroniser, one per bit
module dsi_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					meta_q[i] <= 1'b0;
					q[i]      <= 1'b0;
				end
				else
				begin
					meta_q[i] <= d[i];
					q[i]      <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// file: rtl/dsi_top.sv
// Behaviour
// - only sleep opcode enters sleep
// - sleep blocks write, program, erase commands
// - chip select high gives standby when idle
// - in sleep only wake or reset accepted
// - reset always starts awake, never asleep
// - sleep opcode needs exactly eight bits
// - sleep entered after sleep entry delay
// - sleep opcode rejected while core busy
// - bare wake resumes after wake delay
// - ident after three dummy bytes, msb first
// - ident byte repeats until select rises
// - ident wake from sleep waits second delay
// - ident readout works when never asleep
// - ident readout suppressed while core busy; in sleep the wake is still taken
// - maker then device after zero address
// - address one gives device byte first
module dsi_top
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic sclk,
	input  wire logic csn,
	input  wire logic serial_input,
	input  wire logic busy,
	output logic      so_q,
	output logic      so_en_q,
	output logic      sleep_mode_q,
	output logic      standby_q,
	output logic      cmd_accept_q
);

	// ----------------------------------------------------------------
	// link side: shift in on rising edges
	// ----------------------------------------------------------------
	logic        frame_rst_n;
	logic [5:0]  cnt_q;
	logic [5:0]  cnt_d;
	logic [31:0] shift_q;
	logic [7:0]  op_q;
	logic [7:0]  op_next;
	logic [23:0] addr_next;
	logic        swap_q;
	logic        op_tgl_q;
	logic        extra_tgl_q;
	logic [1:0]  ok_s;
	logic        ident_ok_s;
	logic        mfr_ok_s;
	logic        ident_ok_q;
	logic        mfr_ok_q;

	// frame logic is cleared whenever the host deselects
	assign frame_rst_n = resetn & ~csn;
	assign cnt_d       = (cnt_q == dsi_pkg::CNT_SAT) ? cnt_q : cnt_q + 6'h01;
	assign op_next     = {shift_q[6:0], serial_input};
	assign addr_next   = {shift_q[22:0], serial_input};
	assign ident_ok_s  = ok_s[0];
	assign mfr_ok_s    = ok_s[1];

	always_ff @(posedge sclk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			cnt_q   <= 6'h00;
			shift_q <= 32'h0000_0000;
			swap_q  <= 1'b0;
		end
		else
		begin
			cnt_q   <= cnt_d;
			shift_q <= {shift_q[30:0], serial_input};
			if (cnt_q == dsi_pkg::ADDR_LAST_BIT)
			begin
				swap_q <= (addr_next == dsi_pkg::ADDR_SWAP);
			end
		end
	end

	// opcode and events persist across frames for the core side
	always_ff @(posedge sclk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_q        <= 8'h00;
			op_tgl_q    <= 1'b0;
			extra_tgl_q <= 1'b0;
		end
		else if (!csn)
		begin
			if (cnt_q == dsi_pkg::OP_LAST_BIT)
			begin
				op_q     <= op_next;
				op_tgl_q <= ~op_tgl_q;
			end
			if (cnt_q == dsi_pkg::OP_BITS)
			begin
				extra_tgl_q <= ~extra_tgl_q;
			end
		end
	end

	dsi_sync #(.W(2)) u_sync_link
	(
		.clk    (sclk),
		.resetn (resetn),
		.d      ({mfr_ok_q, ident_ok_q}),
		.q      (ok_s)
	);

	// ----------------------------------------------------------------
	// link side: shift out on falling edges
	// ----------------------------------------------------------------
	logic       data_phase;
	logic       rdi_active;
	logic       mfr_active;
	logic [3:0] idx_q;
	logic [7:0] out_byte;
	logic [2:0] bit_sel;

	assign data_phase = (cnt_q >= dsi_pkg::DATA_START);
	assign rdi_active = (op_q == dsi_pkg::OP_WAKE_IDENT) & ident_ok_s;
	assign mfr_active = (op_q == dsi_pkg::OP_MFR_DEV_ID) & mfr_ok_s;
	assign out_byte   = (rdi_active | (idx_q[3] ^ swap_q)) ? dsi_pkg::DEVICE_ID
	                                                       : dsi_pkg::MAKER_ID;
	assign bit_sel    = 3'h7 - idx_q[2:0];

	always_ff @(negedge sclk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			so_q    <= 1'b0;
			so_en_q <= 1'b0;
			idx_q   <= 4'h0;
		end
		else if (data_phase & (rdi_active | mfr_active))
		begin
			so_en_q <= 1'b1;
			so_q    <= out_byte[bit_sel];
			idx_q   <= idx_q + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// core side: crossing and frame tracking
	// ----------------------------------------------------------------
	logic [2:0] core_s;
	logic       csn_d1_q;
	logic       csn_d2_q;
	logic       csn_d3_q;
	logic       op_t_q;
	logic       ex_t_q;
	logic       cs_rise;
	logic       cs_fall;
	logic       op_evt;
	logic       ex_evt;
	logic       got_op_q;
	logic       extra_q;
	logic [7:0] fop_q;
	logic       frame_ok;
	logic       is_sleep_op;
	logic       is_wake_op;
	logic       is_reset_op;

	dsi_sync #(.W(3)) u_sync_core
	(
		.clk    (clk),
		.resetn (resetn),
		.d      ({extra_tgl_q, op_tgl_q, ~csn}),
		.q      (core_s)
	);

	// select edges lag the toggles so every event of a frame lands first
	assign cs_rise     = csn_d2_q & ~csn_d3_q;
	assign cs_fall     = ~csn_d2_q & csn_d3_q;
	assign op_evt      = core_s[1] ^ op_t_q;
	assign ex_evt      = core_s[2] ^ ex_t_q;
	assign frame_ok    = got_op_q & ~extra_q;
	assign is_sleep_op = (fop_q == dsi_pkg::OP_SLEEP_ENTRY);
	assign is_wake_op  = (fop_q == dsi_pkg::OP_WAKE_IDENT);
	assign is_reset_op = (fop_q == dsi_pkg::OP_SOFT_RESET);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			csn_d1_q <= 1'b1;
			csn_d2_q <= 1'b1;
			csn_d3_q <= 1'b1;
			op_t_q   <= 1'b0;
			ex_t_q   <= 1'b0;
		end
		else
		begin
			csn_d1_q <= ~core_s[0];
			csn_d2_q <= csn_d1_q;
			csn_d3_q <= csn_d2_q;
			op_t_q   <= core_s[1];
			ex_t_q   <= core_s[2];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			got_op_q <= 1'b0;
			extra_q  <= 1'b0;
			fop_q    <= 8'h00;
		end
		else if (cs_fall)
		begin
			got_op_q <= 1'b0;
			extra_q  <= 1'b0;
		end
		else
		begin
			if (op_evt)
			begin
				got_op_q <= 1'b1;
				fop_q    <= op_q;
			end
			if (ex_evt)
			begin
				extra_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// core side: power state machine
	// ----------------------------------------------------------------
	dsi_pkg::dsi_pwr_state_t state_q;
	dsi_pkg::dsi_pwr_state_t state_d;
	logic [dsi_pkg::TMR_W-1:0] tmr_q;
	logic [dsi_pkg::TMR_W-1:0] tmr_d;
	logic                      tmr_zero;

	assign tmr_zero = (tmr_q == '0);

	always_comb
	begin
		state_d = state_q;
		tmr_d   = tmr_zero ? tmr_q : tmr_q - 1'b1;
		case (state_q)
			dsi_pkg::ST_AWAKE:
			begin
				if (cs_rise & frame_ok & is_sleep_op & ~busy)
				begin
					state_d = dsi_pkg::ST_ENTER;
					tmr_d   = dsi_pkg::SLEEP_ENTRY_CYC - 1'b1;
				end
			end
			dsi_pkg::ST_ENTER:
			begin
				if (tmr_zero)
				begin
					state_d = dsi_pkg::ST_SLEEP;
				end
			end
			dsi_pkg::ST_SLEEP:
			begin
				if (cs_rise & got_op_q & is_wake_op)
				begin
					state_d = dsi_pkg::ST_WAKE;
					tmr_d   = extra_q ? dsi_pkg::WAKE_IDENT_CYC - 1'b1
					                  : dsi_pkg::WAKE_CYC - 1'b1;
				end
				else if (cs_rise & frame_ok & is_reset_op)
				begin
					state_d = dsi_pkg::ST_AWAKE;
				end
			end
			dsi_pkg::ST_WAKE:
			begin
				// frames during the wake delay are ignored
				if (tmr_zero)
				begin
					state_d = dsi_pkg::ST_AWAKE;
				end
			end
			default:
			begin
				state_d = dsi_pkg::ST_AWAKE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= dsi_pkg::ST_AWAKE;
			tmr_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
		end
	end

	// ----------------------------------------------------------------
	// core side: status outputs and link gating
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sleep_mode_q <= 1'b0;
			standby_q    <= 1'b0;
			cmd_accept_q <= 1'b0;
			ident_ok_q   <= 1'b0;
			mfr_ok_q     <= 1'b0;
		end
		else
		begin
			sleep_mode_q <= (state_d == dsi_pkg::ST_SLEEP);
			standby_q    <= (state_d == dsi_pkg::ST_AWAKE) & csn_d1_q & ~busy;
			cmd_accept_q <= (state_d == dsi_pkg::ST_AWAKE);
			ident_ok_q   <= ~busy & ((state_d == dsi_pkg::ST_AWAKE)
			                       | (state_d == dsi_pkg::ST_SLEEP));
			mfr_ok_q     <= ~busy & (state_d == dsi_pkg::ST_AWAKE);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sleep_entry_time_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_AWAKE && state_d == dsi_pkg::ST_ENTER)
		|=> (state_q == dsi_pkg::ST_ENTER) && (tmr_q == dsi_pkg::SLEEP_ENTRY_CYC - 1'b1))
		else $error("sleep entry delay not loaded");

	enter_to_sleep_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_ENTER && tmr_zero) |=> state_q == dsi_pkg::ST_SLEEP ##1 sleep_mode_q)
		else $error("sleep not entered after delay");

	sleep_only_via_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_SLEEP && $past(state_q) != dsi_pkg::ST_SLEEP)
		|-> $past(state_q) == dsi_pkg::ST_ENTER)
		else $error("sleep reached without entry sequence");

	busy_reject_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_AWAKE && busy) |=> state_q != dsi_pkg::ST_ENTER)
		else $error("sleep entered while busy");

	sleep_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		sleep_mode_q |-> !cmd_accept_q && !mfr_ok_q)
		else $error("commands open during sleep");

	sleep_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_SLEEP && cs_rise && !is_wake_op && !is_reset_op)
		|=> state_q == dsi_pkg::ST_SLEEP)
		else $error("sleep left on an ignored command");

	wake_load_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_SLEEP && cs_rise && got_op_q && is_wake_op && !extra_q)
		|=> state_q == dsi_pkg::ST_WAKE && tmr_q == dsi_pkg::WAKE_CYC - 1'b1)
		else $error("bare wake delay not loaded");

	ident_wake_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == dsi_pkg::ST_SLEEP && cs_rise && got_op_q && is_wake_op && extra_q)
		|=> state_q == dsi_pkg::ST_WAKE && tmr_q == dsi_pkg::WAKE_IDENT_CYC - 1'b1)
		else $error("ident wake delay not loaded");

	standby_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		standby_q |-> $past(csn_d1_q) && !$past(busy))
		else $error("standby while selected or busy");

	out_phase_a: assert property (@(negedge sclk) disable iff (!frame_rst_n)
		so_en_q |-> cnt_q >= dsi_pkg::DATA_START)
		else $error("output before dummy bytes done");

	out_msb_a: assert property (@(negedge sclk) disable iff (!frame_rst_n)
		(so_en_q && !$past(so_en_q) && mfr_active && !swap_q) |-> so_q == dsi_pkg::MAKER_ID[7])
		else $error("maker byte not msb first");

endmodule

// file: tb/dsi_host.sv
// ----------------------------------------------------------------
// host spi controller model, mode 0 or mode 3
// ----------------------------------------------------------------
module dsi_host
(
	output logic      sclk,
	output logic      csn,
	output logic      serial_input,
	input  wire logic so_q,
	input  wire logic so_en_q
);
	timeunit 1ns;
	timeprecision 1ps;

	logic idle_hi;

	initial
	begin
		idle_hi = 1'b0;
		sclk = 1'b0;
		csn = 1'b1;
		serial_input = 1'b0;
	end

	// idle clock level between frames: low for mode 0, high for mode 3
	task automatic set_idle(input logic hi);
		idle_hi = hi;
		sclk = hi;
	endtask

	// nb bits from tx msb down, then nrx bits read; csn low throughout
	task automatic frame(input logic [31:0] tx, input int nb, input int nrx,
		output logic [23:0] rx, output logic en);
		int i;
		rx = 24'h000000;
		en = 1'b0;
		csn = 1'b0;
		#15;
		for (i = 0; i < nb + nrx; i++)
		begin
			sclk = 1'b0;
			// data changes on falling edge; dummy or address bits included
			serial_input = (i < nb) ? tx[31 - i] : ~serial_input;
			#15;
			sclk = 1'b1;
			if (i >= nb)
			begin
				rx = {rx[22:0], so_q};
				en = en | so_en_q;
			end
			#15;
		end
		sclk = idle_hi;
		#15;
		csn = 1'b1;
		// released line shows no stale value
		serial_input = ~serial_input;
	endtask
endmodule

// file: tb/testbench.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        resetn;
	logic        busy;
	logic        sclk;
	logic        csn;
	logic        serial_input;
	logic        so_q;
	logic        so_en_q;
	logic        sleep_mode_q;
	logic        standby_q;
	logic        cmd_accept_q;
	logic [23:0] rx;
	logic        en;
	int          n_mismatch;
	int          compares;
	int          n;

	dsi_top u_dsi_top
	(
		.clk          (clk),
		.resetn       (resetn),
		.sclk         (sclk),
		.csn          (csn),
		.serial_input (serial_input),
		.busy         (busy),
		.so_q         (so_q),
		.so_en_q      (so_en_q),
		.sleep_mode_q (sleep_mode_q),
		.standby_q    (standby_q),
		.cmd_accept_q (cmd_accept_q)
	);

	dsi_host u_dsi_host
	(
		.sclk         (sclk),
		.csn          (csn),
		.serial_input (serial_input),
		.so_q         (so_q),
		.so_en_q      (so_en_q)
	);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function automatic logic sel(input int w);
		return (w == 0) ? sleep_mode_q : (w == 1) ? cmd_accept_q : standby_q;
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wait_sig(input int w, input logic v, input int bound, output int k);
		for (k = 0; k < bound; k++)
		begin
			cyc(1);
			if (sel(w) === v)
				return;
		end
		n_mismatch++;
		$display("[FAIL] t=%0t got %h exp %h", $time, sel(w), v);
		summarize();
	endtask

	task automatic op(input logic [7:0] o, input int nb, input int nrx);
		u_dsi_host.frame({o, 24'h000000}, nb, nrx, rx, en);
	endtask

	task automatic sleep_in();
		op(dsi_pkg::OP_SLEEP_ENTRY, 8, 0);
		wait_sig(0, 1'b1, 300, n);
		`CHK((n >= int'(dsi_pkg::SLEEP_ENTRY_CYC)) && (n <= int'(dsi_pkg::SLEEP_ENTRY_CYC) + 12), 1'b1)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		cyc(10);
		`CHK(sleep_mode_q, 1'b0)
		`CHK(cmd_accept_q, 1'b1)
		`CHK(standby_q, 1'b1)
		$display("test reset done");
	endtask

	task automatic t_ident();
		op(dsi_pkg::OP_WAKE_IDENT, 32, 20);
		`CHK(rx[19:0], {dsi_pkg::DEVICE_ID, dsi_pkg::DEVICE_ID, dsi_pkg::DEVICE_ID[7:4]})
		`CHK(en, 1'b1)
		cyc(8);
		`CHK(standby_q, 1'b1)
		`CHK(sleep_mode_q, 1'b0)
		$display("test ident done");
	endtask

	task automatic t_mfr();
		int a;
		for (a = 0; a < 2; a++)
		begin
			u_dsi_host.frame({dsi_pkg::OP_MFR_DEV_ID, 24'(a)}, 32, 24, rx, en);
			`CHK(rx, a ? {dsi_pkg::DEVICE_ID, dsi_pkg::MAKER_ID, dsi_pkg::DEVICE_ID} : {dsi_pkg::MAKER_ID, dsi_pkg::DEVICE_ID, dsi_pkg::MAKER_ID})
			cyc(8);
		end
		$display("test maker device done");
	endtask

	task automatic t_long_sleep();
		op(dsi_pkg::OP_SLEEP_ENTRY, 9, 0);
		cyc(120);
		`CHK(sleep_mode_q, 1'b0)
		`CHK(cmd_accept_q, 1'b1)
		$display("test nine bit sleep done");
	endtask

	task automatic t_sleep_wake();
		sleep_in();
		`CHK(cmd_accept_q, 1'b0)
		op(dsi_pkg::OP_MFR_DEV_ID, 32, 16);
		`CHK(en, 1'b0)
		cyc(8);
		`CHK(sleep_mode_q, 1'b1)
		op(dsi_pkg::OP_WAKE_IDENT, 8, 0);
		// csn held high for the whole wait
		wait_sig(1, 1'b1, 300, n);
		`CHK((n >= int'(dsi_pkg::WAKE_CYC)) && (n <= int'(dsi_pkg::WAKE_CYC) + 12), 1'b1)
		`CHK(sleep_mode_q, 1'b0)
		$display("test sleep wake done");
	endtask

	task automatic t_sleep_ident();
		sleep_in();
		op(dsi_pkg::OP_WAKE_IDENT, 32, 8);
		`CHK(rx[7:0], dsi_pkg::DEVICE_ID)
		wait_sig(2, 1'b1, 300, n);
		`CHK((n >= int'(dsi_pkg::WAKE_IDENT_CYC)) && (n <= int'(dsi_pkg::WAKE_IDENT_CYC) + 12), 1'b1)
		$display("test sleep ident done");
	endtask

	task automatic t_soft();
		sleep_in();
		op(dsi_pkg::OP_SOFT_RESET, 8, 0);
		wait_sig(0, 1'b0, 10, n);
		wait_sig(1, 1'b1, 10, n);
		cyc(8);
		$display("test soft reset done");
	endtask

	task automatic t_power();
		sleep_in();
		resetn = 1'b0;
		cyc(4);
		resetn = 1'b1;
		cyc(10);
		`CHK(sleep_mode_q, 1'b0)
		`CHK(cmd_accept_q, 1'b1)
		$display("test power cycle done");
	endtask

	task automatic t_mode3();
		u_dsi_host.set_idle(1'b1);
		cyc(2);
		op(dsi_pkg::OP_WAKE_IDENT, 32, 16);
		`CHK(rx[15:0], {dsi_pkg::DEVICE_ID, dsi_pkg::DEVICE_ID})
		`CHK(en, 1'b1)
		u_dsi_host.set_idle(1'b0);
		cyc(8);
		$display("test mode three done");
	endtask

	task automatic t_busy();
		busy = 1'b1;
		cyc(8);
		`CHK(standby_q, 1'b0)
		op(dsi_pkg::OP_SLEEP_ENTRY, 8, 0);
		cyc(120);
		`CHK(sleep_mode_q, 1'b0)
		op(dsi_pkg::OP_WAKE_IDENT, 32, 8);
		`CHK(en, 1'b0)
		cyc(1);
		busy = 1'b0;
		cyc(8);
		`CHK(standby_q, 1'b1)
		$display("test busy done");
	endtask

	initial
	begin
		n_mismatch = 0;
		compares = 0;
		resetn = 1'b0;
		busy = 1'b0;
		cyc(20);
		resetn = 1'b1;
		t_reset();
		t_ident();
		t_mfr();
		t_long_sleep();
		t_sleep_wake();
		t_sleep_ident();
		t_soft();
		t_power();
		t_mode3();
		t_busy();
		summarize();
	end
endmodule
